// *** csc_store_unit.sv ***
// Core storage unit: storage clock, line selection, sense and inhibit.
`timescale 1ns/10ps
`default_nettype none
module csc_store_unit (
  input wire logic clk,
  input wire logic sys_rst,
  csc_link_if.device link,
  output logic x_read_phase,
  output logic x_read_drv,
  output logic x_write_drv,
  output logic x_src_read,
  output logic x_src_write,
  output logic y_read_drv,
  output logic y_write_drv,
  output logic y_src_read,
  output logic y_src_write,
  output logic [csc_pkg::XSEL_W-1:0] x_src_sel,
  output logic [csc_pkg::XSEL_W-1:0] x_sink_sel,
  output logic [csc_pkg::YSRC_W-1:0] y_src_sel,
  output logic [csc_pkg::XSEL_W-1:0] y_sink_sel,
  output logic sense_amp_gate_even,
  output logic sense_amp_gate_odd,
  output logic sense_strobe,
  output logic clock_delay_tap,
  output logic main_area,
  output csc_pkg::csc_byte_t inhibit_even,
  output csc_pkg::csc_byte_t inhibit_odd
);
  import csc_pkg::*;

  logic rd_q;
  logic wr_q;
  csc_cnt_t cnt_q;
  csc_byte_t core_q [0:CORE_DEPTH-1];
  logic [CORE_AW-1:0] core_idx;
  logic go;
  logic lowest_sec;
  logic phase1;
  logic phase2;
  logic drive_on;
  logic strobe_now;
  logic store_now;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and storage clock timing.

  // seven-bit Y address with six-bit X address
  assign core_idx = {link.addr_hi[3:7], link.addr_lo[0:7]};
  assign go = !link.addr_hi[HI_GO_BIT];
  assign lowest_sec = !link.addr_hi[HI_SEC1_BIT] && !link.addr_hi[HI_SEC2_BIT];
  assign phase1 = (cnt_q >= T_PHASE1_ON) && (cnt_q < T_DRIVE_OFF);
  assign phase2 = (cnt_q >= T_PHASE2_ON) && (cnt_q < T_DRIVE_OFF);
  assign drive_on = phase1 && (rd_q || wr_q);
  assign strobe_now = rd_q && (cnt_q == T_STROBE);
  assign store_now = wr_q && (cnt_q == T_STORE);

  ////////////////////////////////////////////////////////////////////////////
  // Phase latches and the storage clock.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (rd_q || wr_q) begin
      if (cnt_q == T_END) begin
        rd_q <= 1'b0;
        wr_q <= 1'b0;
      end
    end else if (link.read_call) begin
      rd_q <= !clock_delay_tap;
    end else if (link.write_call) begin
      wr_q <= go;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !(rd_q || wr_q) || cnt_q == T_END) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // The tap rises part way through each clock run; it is always low when a read call is taken, so it blocks no read.
  always_ff @(posedge clk) begin
    if (sys_rst || cnt_q == T_END) begin
      clock_delay_tap <= 1'b0;
    end else if ((rd_q || wr_q) && cnt_q >= DELAY_TAP_CYC) begin
      clock_delay_tap <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_area <= 1'b0;
    end else if (link.read_call && !rd_q && !wr_q) begin
      main_area <= !link.early_aux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.busy <= 1'b0;
    end else begin
      link.busy <= (rd_q || wr_q) && (cnt_q != T_END);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive line selection.

  always_ff @(posedge clk) begin
    if (sys_rst || !drive_on) begin
      x_src_sel <= '0;
      x_sink_sel <= '0;
      y_src_sel <= '0;
      y_sink_sel <= '0;
    end else begin
      x_src_sel <= 8'h01 << link.addr_lo[5:7];
      x_sink_sel <= 8'h01 << link.addr_lo[2:4];
      y_src_sel <= 16'h0001 << {link.addr_hi[6:7], link.addr_lo[0:1]};
      y_sink_sel <= 8'h01 << link.addr_hi[3:5];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_read_phase <= 1'b0;
      x_read_drv <= 1'b0;
      x_src_read <= 1'b0;
      y_read_drv <= 1'b0;
      y_src_read <= 1'b0;
    end else begin
      x_read_phase <= rd_q && phase1;
      x_read_drv <= rd_q && phase1 && lowest_sec;
      x_src_read <= rd_q && phase1 && go && !link.addr_hi[HI_SEC2_BIT];
      y_read_drv <= rd_q && phase2 && main_area;
      y_src_read <= rd_q && phase2 && go;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_write_drv <= 1'b0;
      x_src_write <= 1'b0;
      y_write_drv <= 1'b0;
      y_src_write <= 1'b0;
    end else begin
      x_write_drv <= wr_q && phase1 && lowest_sec;
      x_src_write <= wr_q && phase1 && go && !link.addr_hi[HI_SEC2_BIT];
      y_write_drv <= wr_q && phase2 && main_area;
      y_src_write <= wr_q && phase2 && go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense path.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_amp_gate_even <= 1'b0;
      sense_amp_gate_odd <= 1'b0;
      sense_strobe <= 1'b0;
    end else begin
      sense_amp_gate_even <= rd_q && phase1 && lowest_sec && !link.addr_lo[LO_PARITY_BIT];
      sense_amp_gate_odd <= rd_q && phase1 && lowest_sec && link.addr_lo[LO_PARITY_BIT];
      sense_strobe <= strobe_now;
    end
  end

  // Latches clear as the read starts so a core that does not switch reads zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.rdata <= CLEARED_BYTE;
    end else if (link.read_call && !rd_q && !wr_q) begin
      link.rdata <= CLEARED_BYTE;
    end else if (strobe_now && lowest_sec && go) begin
      link.rdata <= core_q[core_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.data_ready <= 1'b0;
    end else begin
      link.data_ready <= rd_q && (cnt_q == T_READY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core array. Contents are not reset, as a real array keeps no known value.

  always_ff @(posedge clk) begin
    if (!sys_rst && lowest_sec && go) begin
      if (strobe_now) begin
        core_q[core_idx] <= CLEARED_BYTE;
      end else if (store_now) begin
        core_q[core_idx] <= link.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inhibit_even <= CLEARED_BYTE;
      inhibit_odd <= CLEARED_BYTE;
    end else begin
      inhibit_even <= (wr_q && phase1 && lowest_sec && !link.addr_lo[LO_PARITY_BIT])
                      ? ~link.wdata : CLEARED_BYTE;
      inhibit_odd <= (wr_q && phase1 && lowest_sec && link.addr_lo[LO_PARITY_BIT])
                     ? ~link.wdata : CLEARED_BYTE;
    end
  end

endmodule
`default_nettype wire

// *** csc_pkg.sv ***
// Shared constants and types for the core store cycle control link.
`default_nettype none
package csc_pkg;

  // Clock and the self-timed storage clock.
  localparam int CLK_PERIOD_NS = 40;
  localparam int DELAY_TAP_NS = 200;
  localparam int DELAY_TAP_CYC_I = (DELAY_TAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  typedef logic [CNT_W-1:0] csc_cnt_t;
  localparam csc_cnt_t DELAY_TAP_CYC = csc_cnt_t'(DELAY_TAP_CYC_I);

  // Storage clock timing points, counted from the request edge.
  localparam csc_cnt_t T_PHASE1_ON = 4'h1;
  localparam csc_cnt_t T_PHASE2_ON = 4'h2;
  localparam csc_cnt_t T_DRIVE_OFF = 4'h6;
  localparam csc_cnt_t T_STROBE = 4'h5;
  localparam csc_cnt_t T_READY = 4'h7;
  localparam csc_cnt_t T_STORE = 4'h5;
  localparam csc_cnt_t T_END = 4'h9;

  // Address registers are numbered with bit 0 as the most significant bit.
  typedef logic [0:7] csc_addr_t;
  localparam int HI_GO_BIT = 0;
  localparam int HI_SEC1_BIT = 1;
  localparam int HI_SEC2_BIT = 2;
  localparam int LO_PARITY_BIT = 7;

  // A byte is parity in bit 8 and data bits 0 to 7 in indices 7 down to 0.
  localparam int BYTE_W = 9;
  typedef logic [BYTE_W-1:0] csc_byte_t;
  localparam csc_byte_t CLEARED_BYTE = 9'h000;

  localparam int CORE_AW = 13;
  localparam int CORE_DEPTH = 8192;
  localparam int XSEL_W = 8;
  localparam int YSRC_W = 16;

endpackage
`default_nettype wire

// *** csc_link_if.sv ***
// Link between the processor end and the core storage unit.
`timescale 1ns/10ps
`default_nettype none
interface csc_link_if;
  import csc_pkg::*;

  csc_addr_t addr_hi;
  csc_addr_t addr_lo;
  csc_byte_t wdata;
  logic read_call;
  logic write_call;
  logic early_aux;
  csc_byte_t rdata;
  logic data_ready;
  logic busy;

  modport device (
    input addr_hi,
    input addr_lo,
    input wdata,
    input read_call,
    input write_call,
    input early_aux,
    output rdata,
    output data_ready,
    output busy
  );

  modport processor (
    output addr_hi,
    output addr_lo,
    output wdata,
    output read_call,
    output write_call,
    output early_aux,
    input rdata,
    input data_ready,
    input busy
  );
endinterface
`default_nettype wire

// *** csc_proc_end.sv ***
// Processor end: runs a read then a write for each command.
`timescale 1ns/10ps
`default_nettype none
module csc_proc_end (
  input wire logic clk,
  input wire logic sys_rst,
  csc_link_if.processor link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire csc_pkg::csc_addr_t cmd_addr_hi,
  input wire csc_pkg::csc_addr_t cmd_addr_lo,
  input wire logic cmd_store,
  input wire csc_pkg::csc_byte_t cmd_wdata,
  output logic rsp_valid,
  output csc_pkg::csc_byte_t rsp_data
);
  import csc_pkg::*;

  typedef enum logic [2:0] {
    CSCP_IDLE = 3'b000,
    CSCP_RD_WAIT = 3'b001,
    CSCP_WR_HOLD = 3'b010,
    CSCP_WR_WAIT = 3'b011,
    CSCP_RD_CALL = 3'b100
  } cscp_state_e;

  cscp_state_e state_q;
  logic store_q;
  csc_byte_t store_data_q;
  logic wr_sent_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing.

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= CSCP_IDLE;
    end else begin
      case (state_q)
        CSCP_IDLE: begin
          if (cmd_valid) begin
            state_q <= CSCP_RD_CALL;
          end
        end
        CSCP_RD_CALL: begin
          if (!link.busy) begin
            state_q <= CSCP_RD_WAIT;
          end
        end
        CSCP_RD_WAIT: begin
          if (link.data_ready) begin
            state_q <= CSCP_WR_HOLD;
          end
        end
        CSCP_WR_HOLD: begin
          if (!link.busy) begin
            state_q <= CSCP_WR_WAIT;
          end
        end
        CSCP_WR_WAIT: begin
          if (!link.busy && !link.write_call && !wr_sent_q) begin
            state_q <= CSCP_IDLE;
          end
        end
        default: begin
          state_q <= CSCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.addr_hi <= '0;
      link.addr_lo <= '0;
      store_q <= 1'b0;
      store_data_q <= CLEARED_BYTE;
    end else if (state_q == CSCP_IDLE && cmd_valid) begin
      link.addr_hi <= cmd_addr_hi;
      link.addr_lo <= cmd_addr_lo;
      store_q <= cmd_store;
      store_data_q <= cmd_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.read_call <= 1'b0;
      link.write_call <= 1'b0;
      link.early_aux <= 1'b0;
    end else begin
      link.read_call <= (state_q == CSCP_RD_CALL) && !link.busy;
      link.write_call <= (state_q == CSCP_WR_HOLD) && !link.busy;
      link.early_aux <= 1'b0;
    end
  end

  // Busy shows two edges after the write call. Without this cover, the next address could
  // reach the link while the store is still running.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_sent_q <= 1'b0;
    end else begin
      wr_sent_q <= link.write_call;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.wdata <= CLEARED_BYTE;
      rsp_data <= CLEARED_BYTE;
    end else if (state_q == CSCP_RD_WAIT && link.data_ready) begin
      link.wdata <= store_q ? store_data_q : link.rdata;
      rsp_data <= link.rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      cmd_ready <= (state_q == CSCP_IDLE) && !cmd_valid && !cmd_ready;
      rsp_valid <= (state_q == CSCP_WR_WAIT) && !link.busy && !link.write_call && !wr_sent_q;
    end
  end

endmodule
`default_nettype wire

// *** csc_link_asserts.sv ***
// Concurrent checks on the link between the processor end and the storage unit.
`timescale 1ns/10ps
`default_nettype none
module csc_link_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire csc_pkg::csc_addr_t addr_hi,
  input wire csc_pkg::csc_addr_t addr_lo,
  input wire csc_pkg::csc_byte_t wdata,
  input wire logic read_call,
  input wire logic write_call,
  input wire logic early_aux,
  input wire csc_pkg::csc_byte_t rdata,
  input wire logic data_ready,
  input wire logic busy
);
  import csc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // A read leaves its location cleared until the matching write is taken.
  logic pend_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (read_call && !busy) begin
      pend_q <= 1'b1;
    end else if (write_call && !busy) begin
      pend_q <= 1'b0;
    end
  end
  sequence s_read_taken;
    read_call && !busy && !pend_q;
  endsequence
  sequence s_write_taken;
    write_call && !busy && !addr_hi[HI_GO_BIT];
  endsequence
  ////////////////////////////////////////////////////////////
  property p_read_start;
    s_read_taken |-> ##[1:3] busy;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read did not start");
  property p_read_clear;
    s_read_taken |-> ##2 (rdata == CLEARED_BYTE);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("data not cleared");
  property p_read_ready;
    s_read_taken |-> ##[8:10] data_ready;
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("no data ready");
  property p_ready_pulse;
    data_ready |=> !data_ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_busy;
    data_ready |-> busy;
  endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready while idle");
  property p_busy_bound;
    $rose(busy) |-> busy[*6] ##[1:5] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy length wrong");
  property p_write_start;
    s_write_taken |-> ##[1:3] busy;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not start");
  property p_no_double_read;
    read_call && !busy |-> !pend_q;
  endproperty
  a_no_double_read: assert property (p_no_double_read) else $error("read after read");
  property p_addr_held;
    pend_q |-> $stable(addr_hi) && $stable(addr_lo);
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("address moved");
  property p_rdata_hold;
    s_write_taken |=> $stable(rdata)[*8];
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("data latch moved");
  property p_addr_busy;
    busy |-> $stable(addr_hi) && $stable(addr_lo);
  endproperty
  a_addr_busy: assert property (p_addr_busy) else $error("address moved in cycle");
  property p_wdata_hold;
    s_write_taken |=> $stable(wdata)[*8];
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write byte moved");
endmodule
`default_nettype wire

// *** core_store_cycle_control_tb_top.sv ***
// Testbench joining the processor end and the storage unit over the link.
`timescale 1ns/10ps
`default_nettype none
module core_store_cycle_control_tb_top;
  import csc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_store = 1'b0;
  csc_addr_t cmd_addr_hi = 8'h00;
  csc_addr_t cmd_addr_lo = 8'h00;
  csc_byte_t cmd_wdata = 9'h000;
  logic cmd_ready, rsp_valid, x_src_read, x_src_write, y_src_read;
  logic x_read_drv, x_write_drv, y_read_drv, gate_even;
  logic [YSRC_W-1:0] y_src_sel;
  csc_byte_t rsp_data, inhibit_even, inhibit_odd;
  logic [XSEL_W-1:0] x_src_sel, x_sink_sel, y_sink_sel;
  int err_total = 0;
  int checks = 0;
  csc_addr_t hi_t [6] = '{8'h00, 8'h00, 8'h00, 8'h1F, 8'h08, 8'h00};
  csc_addr_t lo_t [6] = '{8'h29, 8'h28, 8'h00, 8'hFF, 8'h29, 8'hC0};
  csc_byte_t val_t [6] = '{9'h02D, 9'h1D2, 9'h000, 9'h1FF, 9'h155, 9'h0AA};
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  csc_link_if link ();
  csc_proc_end csc_proc_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr_hi(cmd_addr_hi),
    .cmd_addr_lo(cmd_addr_lo), .cmd_store(cmd_store), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  csc_store_unit csc_store_unit_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .x_read_phase(), .x_read_drv(x_read_drv), .x_write_drv(x_write_drv),
    .x_src_read(x_src_read), .x_src_write(x_src_write), .y_read_drv(y_read_drv),
    .y_write_drv(), .y_src_read(y_src_read), .y_src_write(), .x_src_sel(x_src_sel),
    .x_sink_sel(x_sink_sel), .y_src_sel(y_src_sel), .y_sink_sel(y_sink_sel),
    .sense_amp_gate_even(gate_even), .sense_amp_gate_odd(), .sense_strobe(),
    .clock_delay_tap(), .main_area(), .inhibit_even(inhibit_even),
    .inhibit_odd(inhibit_odd));
  csc_link_asserts csc_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
    .addr_hi(link.addr_hi), .addr_lo(link.addr_lo), .wdata(link.wdata),
    .read_call(link.read_call), .write_call(link.write_call), .early_aux(link.early_aux),
    .rdata(link.rdata), .data_ready(link.data_ready), .busy(link.busy));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Valid is held until the read call shows, so one command is never taken twice.
  task automatic access(input csc_addr_t hi, input csc_addr_t lo, input logic st,
                        input csc_byte_t wd, output csc_byte_t rd);
    int n;
    @(negedge clk);
    cmd_addr_hi = hi;
    cmd_addr_lo = lo;
    cmd_store = st;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    n = 0;
    while (link.read_call !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 120) begin
      @(negedge clk);
      n++;
    end
    chk("access_done", 16'h0000, 16'(n >= 120));
    rd = rsp_data;
  endtask
  ////////////////////////////////////////////////////////////
  // Only the lowest section holds cores, so only there do X drivers, gates and inhibits act; Y drivers follow main_area.
  always @(negedge clk) begin
    csc_byte_t inh_exp;
    logic low_sec;
    inh_exp = ~link.wdata;
    low_sec = !link.addr_hi[1] && !link.addr_hi[2];
    if (x_src_read === 1'b1) begin
      chk("x_src_sel", 16'(8'h01 << link.addr_lo[5:7]), 16'(x_src_sel));
      chk("x_sink_sel", 16'(8'h01 << link.addr_lo[2:4]), 16'(x_sink_sel));
      chk("x_read_drv", 16'(low_sec), 16'(x_read_drv));
      chk("gate_even", 16'(low_sec && !link.addr_lo[7]), 16'(gate_even));
    end
    if (y_src_read === 1'b1) begin
      chk("y_sink_sel", 16'(8'h01 << link.addr_hi[3:5]), 16'(y_sink_sel));
      chk("y_src_sel", 16'(16'h0001 << {link.addr_hi[6:7], link.addr_lo[0:1]}),
          16'(y_src_sel));
      chk("y_read_drv", 16'h0001, 16'(y_read_drv));
    end
    if (x_src_write === 1'b1) begin
      chk("x_write_drv", 16'(low_sec), 16'(x_write_drv));
      chk("inh_even", 16'(low_sec && !link.addr_lo[7] ? inh_exp : 9'h000),
          16'(inhibit_even));
      chk("inh_odd", 16'(low_sec && link.addr_lo[7] ? inh_exp : 9'h000),
          16'(inhibit_odd));
    end
  end
  // The whole run needs about seven hundred cycles; seven times that means a hang.
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    csc_byte_t rd;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      access(hi_t[i], lo_t[i], 1'b1, val_t[i], rd);
    end
    // Two fetch passes: the second proves the first one restored each byte.
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        access(hi_t[i], lo_t[i], 1'b0, 9'h000, rd);
        chk("fetch", 16'(val_t[i]), 16'(rd));
      end
    end
    access(hi_t[0], lo_t[0], 1'b1, 9'h100, rd);
    chk("old_byte", 16'(val_t[0]), 16'(rd));
    access(hi_t[0], lo_t[0], 1'b0, 9'h000, rd);
    chk("new_byte", 16'h0100, 16'(rd));
    access(hi_t[2], lo_t[2], 1'b0, 9'h000, rd);
    chk("zero_byte", 16'(CLEARED_BYTE), 16'(rd));
    access(8'h20, 8'h29, 1'b1, 9'h1FF, rd);
    access(8'h20, 8'h29, 1'b0, 9'h000, rd);
    chk("upper_sect", 16'(CLEARED_BYTE), 16'(rd));
    access(8'h40, 8'h28, 1'b1, 9'h1FF, rd);
    access(8'h40, 8'h28, 1'b0, 9'h000, rd);
    chk("upper_gate", 16'(CLEARED_BYTE), 16'(rd));
    access(hi_t[1], lo_t[1], 1'b0, 9'h000, rd);
    chk("kept_byte", 16'(val_t[1]), 16'(rd));
    give_verdict();
  end
endmodule
`default_nettype wire
